/* verilog/stmr_defs.svh */
`ifndef STMR_DEFS_SVH
`define STMR_DEFS_SVH
// ==========================================================================
// Register addresses
`define STMR_ADDR_CTRL      2'h0
`define STMR_ADDR_LOW       2'h1
`define STMR_ADDR_HIGH      2'h2
`define STMR_ADDR_IRQ       2'h3
// ==========================================================================
// Control field positions
`define STMR_BIT_WIDE       7
`define STMR_BIT_SYSCLK     6
`define STMR_BIT_PS_HI      5
`define STMR_BIT_PS_LO      4
`define STMR_BIT_OSCEN      3
`define STMR_BIT_NOSYNC     2
`define STMR_BIT_CS         1
`define STMR_BIT_RUN        0
// Interrupt register: flag in bit 0, enable in bit 1.
`define STMR_BIT_IRQ_FLAG   0
`define STMR_BIT_IRQ_EN     1
// ==========================================================================
// Reset values and constants
`define STMR_CTRL_RESET     8'h00
`define STMR_BYTE_ZERO      8'h00
`define STMR_CNT_MAX        16'hffff
`define STMR_CNT_ZERO       16'h0000
`define STMR_CNT_ONE        16'h0001
`define STMR_PS_ZERO        3'h0
`define STMR_PS_ONE         3'h1
`define STMR_INSTR_DIV_M1   2'h3
`define STMR_CCP_SPECIAL    4'hb
`endif

/* verilog/stmr_pkg.sv */
package stmr_pkg;
  typedef enum logic [1:0] {
    STMR_PS_1 = 2'h0,
    STMR_PS_2 = 2'h1,
    STMR_PS_4 = 2'h2,
    STMR_PS_8 = 2'h3
  } stmr_ps_t;
endpackage : stmr_pkg

/* verilog/stmr_timer.sv */
// What this block does
// - Control bit 7 set gives buffered 16-bit access; clear gives two byte accesses.
// - Read-only bit 6 reads 1 when system clock comes from secondary oscillator.
// - Bits 5-4 prescale the counter input: 1:1, 1:2, 1:4, 1:8.
// - Control bit 3 enables the secondary oscillator; clear shuts it off.
// - Bit 2 set only drops the trigger reset with external clock; edges stay synchronized; ignored with internal clock.
// - Bit 1 set counts external or oscillator rising edges; clear counts Fosc/4.
// - Control bit 0 starts and stops the counter.
// - Internal source advances once per instruction cycle, ahead of the prescaler.
// - With oscillator enabled, both oscillator pins are inputs and read 0.
// - Count runs 0000h to FFFFh, wraps, and the wrap sets the overflow flag.
// - Overflow flag gives an interrupt request only while its enable is set.
// - Compare mode 1011 special event trigger resets the counter.
// - Trigger-caused reset does not set the overflow flag.
// - Trigger reset is guaranteed only in timer or synchronized counter mode.
// - A software counter write wins over a simultaneous trigger reset.
// - Buffered mode: high address hits buffer; low read copies live high byte.
// - Buffered mode: low write loads high byte from buffer simultaneously.
// - Low byte writes clear the prescaler; high byte writes do not.
// - Enabled secondary oscillator keeps running in all power-managed modes.
//
// The address map and the plain strobed port were left to the implementer.
`include "stmr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module stmr_timer (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_ext_count_clock_pin,
  input  wire logic       i_crystal_in_pin,
  input  wire logic       i_osc_sysclk_sel,
  input  wire logic [3:0] i_compare_unit_mode_field,
  input  wire logic       i_compare_match,
  input  wire logic [1:0] i_osc_pin_direction_bits,
  input  wire logic [1:0] i_osc_pin_out_data,
  input  wire logic [1:0] i_osc_pin_in_raw,
  output logic      [1:0] o_osc_pin_oe,
  output logic      [1:0] o_osc_pin_out,
  output logic      [1:0] o_osc_pin_read,
  output logic            o_osc_amp_enable,
  output logic            o_overflow_irq
);
  // ========================================================================
  // State
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] cnt;
    logic [7:0]  hbuf;
    logic [2:0]  ps;
    logic [1:0]  icyc;
    logic        flag;
    logic        irq_en;
    logic [1:0]  ext_sync;
    logic [1:0]  osc_sync;
    logic [1:0]  pin_sync0;
    logic [1:0]  pin_sync1;
    logic        src_prev;
    logic        sysclk_s0;
    logic        sysclk_s1;
    logic [7:0]  rdata;
    logic        irq;
    logic [1:0]  pin_oe;
    logic [1:0]  pin_out;
    logic [1:0]  pin_read;
  } stmr_state_t;

  stmr_state_t s_q;
  stmr_state_t s_d;

  function automatic logic [2:0] stmr_ps_limit(input logic [1:0] code);
    case (stmr_pkg::stmr_ps_t'(code))
      stmr_pkg::STMR_PS_1: stmr_ps_limit = 3'h0;
      stmr_pkg::STMR_PS_2: stmr_ps_limit = 3'h1;
      stmr_pkg::STMR_PS_4: stmr_ps_limit = 3'h3;
      stmr_pkg::STMR_PS_8: stmr_ps_limit = 3'h7;
      default:             stmr_ps_limit = 3'h0;
    endcase
  endfunction : stmr_ps_limit

  logic       wide;
  logic       oscen;
  logic       ext_sel;
  logic       src_lvl;
  logic       src_rise;
  logic       tick_in;
  logic       tick;
  logic       wr_low;
  logic       wr_high;
  logic       rd_low;
  logic       trig;

  always_comb begin
    s_d = s_q;
    wide = s_q.ctrl[`STMR_BIT_WIDE];
    oscen = s_q.ctrl[`STMR_BIT_OSCEN];
    ext_sel = s_q.ctrl[`STMR_BIT_CS];
    wr_low = i_wr && (i_addr == `STMR_ADDR_LOW);
    wr_high = i_wr && (i_addr == `STMR_ADDR_HIGH);
    rd_low = i_rd && (i_addr == `STMR_ADDR_LOW);
    // Pin synchronisers; only second stages are read.
    s_d.ext_sync = {s_q.ext_sync[0], i_ext_count_clock_pin};
    s_d.osc_sync = {s_q.osc_sync[0], i_crystal_in_pin};
    s_d.pin_sync0 = i_osc_pin_in_raw;
    s_d.pin_sync1 = s_q.pin_sync0;
    s_d.sysclk_s0 = i_osc_sysclk_sel;
    s_d.sysclk_s1 = s_q.sysclk_s0;
    // the amplifier follows only its enable, never a power mode.
    // oscillator replaces the external pin when enabled.
    src_lvl = oscen ? s_q.osc_sync[1] : s_q.ext_sync[1];
    s_d.src_prev = src_lvl;
    src_rise = src_lvl && !s_q.src_prev;
    // the edge is sampled on the system clock in both sync modes; the
    // unsynchronized option only drops the trigger guarantee below.
    // internal source ticks every fourth system clock.
    s_d.icyc = s_q.icyc + 2'h1;
    tick_in = ext_sel ? src_rise : (s_q.icyc == `STMR_INSTR_DIV_M1);
    tick = 1'b0;
    if (s_q.ctrl[`STMR_BIT_RUN] && tick_in) begin
      if (s_q.ps >= stmr_ps_limit(s_q.ctrl[`STMR_BIT_PS_HI:`STMR_BIT_PS_LO])) begin
        s_d.ps = `STMR_PS_ZERO;
        tick = 1'b1;
      end else begin
        s_d.ps = s_q.ps + `STMR_PS_ONE;
      end
    end
    // trigger ignored in asynchronous counter mode.
    trig = i_compare_match && (i_compare_unit_mode_field == `STMR_CCP_SPECIAL) &&
           !(ext_sel && s_q.ctrl[`STMR_BIT_NOSYNC]);
    if (trig) begin
      s_d.cnt = `STMR_CNT_ZERO;
    end else if (tick) begin
      s_d.cnt = s_q.cnt + `STMR_CNT_ONE;
      if (s_q.cnt == `STMR_CNT_MAX) begin
        s_d.flag = 1'b1;
      end
    end
    // software writes come last so they win over the trigger.
    if (wr_low) begin
      s_d.cnt[7:0] = i_wdata;
      s_d.ps = `STMR_PS_ZERO;
      if (wide) begin
        s_d.cnt[15:8] = s_q.hbuf;
      end
    end
    if (wr_high) begin
      if (wide) begin
        s_d.hbuf = i_wdata;
      end else begin
        s_d.cnt[15:8] = i_wdata;
      end
    end
    if (i_wr && (i_addr == `STMR_ADDR_CTRL)) begin
      s_d.ctrl = i_wdata;
      s_d.ctrl[`STMR_BIT_SYSCLK] = 1'b0;
    end
    if (i_wr && (i_addr == `STMR_ADDR_IRQ)) begin
      s_d.irq_en = i_wdata[`STMR_BIT_IRQ_EN];
      // Hardware set wins over software clear only if the flag was clear before.
      s_d.flag = i_wdata[`STMR_BIT_IRQ_FLAG] || (s_d.flag && !s_q.flag);
    end
    // in buffered mode, reading the low byte snapshots the live high byte.
    if (rd_low && wide) begin
      s_d.hbuf = s_q.cnt[15:8];
    end
    s_d.rdata = `STMR_BYTE_ZERO;
    if (i_rd) begin
      case (i_addr)
        `STMR_ADDR_CTRL: begin
          s_d.rdata = s_q.ctrl;
          s_d.rdata[`STMR_BIT_SYSCLK] = s_q.sysclk_s1;
        end
        `STMR_ADDR_LOW:  s_d.rdata = s_q.cnt[7:0];
        `STMR_ADDR_HIGH: s_d.rdata = wide ? s_q.hbuf : s_q.cnt[15:8];
        `STMR_ADDR_IRQ: begin
          s_d.rdata[`STMR_BIT_IRQ_FLAG] = s_q.flag;
          s_d.rdata[`STMR_BIT_IRQ_EN] = s_q.irq_en;
        end
        default: s_d.rdata = `STMR_BYTE_ZERO;
      endcase
    end
    s_d.irq = s_d.flag && s_d.irq_en;
    // oscillator forces pins to inputs reading zero.
    s_d.pin_oe = oscen ? 2'h0 : ~i_osc_pin_direction_bits;
    s_d.pin_out = i_osc_pin_out_data;
    s_d.pin_read = oscen ? 2'h0 : s_q.pin_sync1;
    if (!i_rst_b) begin
      s_d = '0;
      s_d.ctrl = `STMR_CTRL_RESET;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    s_q <= s_d;
  end

  assign o_rdata = s_q.rdata;
  assign o_osc_pin_oe = s_q.pin_oe;
  assign o_osc_pin_out = s_q.pin_out;
  assign o_osc_pin_read = s_q.pin_read;
  assign o_osc_amp_enable = s_q.ctrl[`STMR_BIT_OSCEN];
  assign o_overflow_irq = s_q.irq;

  // ========================================================================
  // Assertions
  sequence seq_low_write_wide;
    i_wr && (i_addr == `STMR_ADDR_LOW) && s_q.ctrl[`STMR_BIT_WIDE];
  endsequence

  a_stop_holds: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (!s_q.ctrl[`STMR_BIT_RUN] && !i_wr && !i_compare_match) |=> $stable(s_q.cnt))
    else $error("Counter moved while stopped.");
  a_wrap_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (tick && !trig && !i_wr && s_q.cnt == `STMR_CNT_MAX) |=> (s_q.flag && s_q.cnt == 16'h0))
    else $error("Wrap did not set flag.");
  a_irq_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_overflow_irq == (s_q.flag && s_q.irq_en))
    else $error("Interrupt output wrong.");
  a_trig_reset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (trig && !i_wr) |=> (s_q.cnt == 16'h0 && $stable(s_q.flag)))
    else $error("Trigger reset wrong.");
  a_write_wins: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (trig && i_wr && i_addr == `STMR_ADDR_LOW) |=> s_q.cnt[7:0] == $past(i_wdata))
    else $error("Write lost to trigger.");
  a_wide_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    seq_low_write_wide |=> s_q.cnt[15:8] == $past(s_q.hbuf))
    else $error("High byte not loaded from buffer.");
  a_low_read_snap: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_rd && i_addr == `STMR_ADDR_LOW && s_q.ctrl[`STMR_BIT_WIDE] && !i_wr)
    |=> s_q.hbuf == $past(s_q.cnt[15:8]))
    else $error("Buffer not loaded on low read.");
  a_ps_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == `STMR_ADDR_LOW) |=> s_q.ps == 3'h0)
    else $error("Prescaler not cleared.");
  a_pins_input: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    s_q.ctrl[`STMR_BIT_OSCEN] |=> (o_osc_pin_oe == 2'h0 && o_osc_pin_read == 2'h0))
    else $error("Oscillator pins not forced.");
endmodule : stmr_timer
`default_nettype wire

/* tb/stmr_ext_clk_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Count clock pin and crystal, both idle low between bursts.
module stmr_ext_clk_model (
  input  wire logic i_osc_on,
  output logic      o_ext_clk,
  output logic      o_xtal
);
  initial begin
    o_ext_clk = 1'b0;
    o_xtal    = 1'b0;
  end
  task automatic pulse(input int n);
    for (int k = 0; k < n; k++) begin
      o_xtal    = i_osc_on;
      o_ext_clk = !i_osc_on;
      #150;
      o_xtal    = 1'b0;
      o_ext_clk = 1'b0;
      #150;
    end
  endtask : pulse
endmodule : stmr_ext_clk_model
`default_nettype wire

/* tb/sixteen_bit_timer_counter_tb.sv */
`include "stmr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_timer_counter_tb;
  logic       clk, rst_b, wr_s, rd_s, sel, match, amp, irq, ext_clk, xtal;
  logic [1:0] addr, oe, pout, prd;
  logic [7:0] wdata, rdata, v;
  logic [3:0] mode;
  int         error_cnt, n_checks, cyc;
  stmr_timer stmr_timer_i (.i_sys_clk(clk), .i_rst_b(rst_b), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .i_ext_count_clock_pin(ext_clk), .i_crystal_in_pin(xtal), .i_osc_sysclk_sel(sel),
    .i_compare_unit_mode_field(mode), .i_compare_match(match),
    .i_osc_pin_direction_bits(2'h0), .i_osc_pin_out_data(2'h3), .i_osc_pin_in_raw(2'h3),
    .o_osc_pin_oe(oe), .o_osc_pin_out(pout), .o_osc_pin_read(prd),
    .o_osc_amp_enable(amp), .o_overflow_irq(irq));
  stmr_ext_clk_model stmr_ext_clk_model_i (.i_osc_on(amp), .o_ext_clk(ext_clk), .o_xtal(xtal));
  // ==========================================
  // Bus and compare tasks.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask : rng
  task automatic pulse_match;
    @(posedge clk);
    match <= 1'b1;
    @(posedge clk);
    match <= 1'b0;
  endtask : pulse_match
  task automatic clear_count(input logic [7:0] c);
    wr(`STMR_ADDR_CTRL, 8'h00);
    wr(`STMR_ADDR_HIGH, 8'h00);
    wr(`STMR_ADDR_LOW, 8'h00);
    wr(`STMR_ADDR_CTRL, c);
  endtask : clear_count
  // ==========================================
  // Scenarios.
  task automatic t_prescale;
    logic [7:0] w;
    for (int p = 0; p < 4; p++) begin
      clear_count({2'h0, p[1:0], 4'h1});
      repeat (320) @(posedge clk);
      wr(`STMR_ADDR_CTRL, 8'h00);
      rd(`STMR_ADDR_LOW, v);
      rng(v, (8'd80 >> p) - 8'd1, (8'd80 >> p) + 8'd2);
      repeat (40) @(posedge clk);
      rd(`STMR_ADDR_LOW, w);
      chk(w, v);
    end
  endtask : t_prescale
  task automatic t_overflow;
    wr(`STMR_ADDR_HIGH, 8'hff);
    wr(`STMR_ADDR_LOW, 8'hfd);
    wr(`STMR_ADDR_IRQ, 8'h00);
    wr(`STMR_ADDR_CTRL, 8'h01);
    repeat (60) @(posedge clk);
    rd(`STMR_ADDR_IRQ, v);
    chk(v & 8'h01, 8'h01);
    chk({7'h0, irq}, 8'h00);
    wr(`STMR_ADDR_IRQ, 8'h03);
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h01);
    wr(`STMR_ADDR_CTRL, 8'h00);
    rd(`STMR_ADDR_HIGH, v);
    chk(v, 8'h00);
    wr(`STMR_ADDR_IRQ, 8'h00);
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
  endtask : t_overflow
  task automatic t_trigger;
    clear_count(8'h31);
    wr(`STMR_ADDR_LOW, 8'h50);
    pulse_match();
    rd(`STMR_ADDR_LOW, v);
    rng(v, 8'h00, 8'h02);
    rd(`STMR_ADDR_IRQ, v);
    chk(v & 8'h01, 8'h00);
    mode <= 4'ha;
    wr(`STMR_ADDR_LOW, 8'h50);
    pulse_match();
    rd(`STMR_ADDR_LOW, v);
    rng(v, 8'h50, 8'h52);
    mode <= `STMR_CCP_SPECIAL;
    @(posedge clk);
    addr  <= `STMR_ADDR_LOW;
    wdata <= 8'h40;
    wr_s  <= 1'b1;
    match <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    match <= 1'b0;
    rd(`STMR_ADDR_LOW, v);
    rng(v, 8'h40, 8'h42);
    wr(`STMR_ADDR_CTRL, 8'h07);
    wr(`STMR_ADDR_LOW, 8'h50);
    pulse_match();
    rd(`STMR_ADDR_LOW, v);
    chk(v, 8'h50);
  endtask : t_trigger
  task automatic t_buffer;
    wr(`STMR_ADDR_CTRL, 8'h80);
    wr(`STMR_ADDR_HIGH, 8'h12);
    wr(`STMR_ADDR_LOW, 8'h34);
    wr(`STMR_ADDR_HIGH, 8'h99);
    rd(`STMR_ADDR_LOW, v);
    chk(v, 8'h34);
    rd(`STMR_ADDR_HIGH, v);
    chk(v, 8'h12);
    wr(`STMR_ADDR_CTRL, 8'h00);
    wr(`STMR_ADDR_HIGH, 8'h56);
    rd(`STMR_ADDR_HIGH, v);
    chk(v, 8'h56);
  endtask : t_buffer
  task automatic t_ext;
    clear_count(8'h03);
    stmr_ext_clk_model_i.pulse(5);
    repeat (10) @(posedge clk);
    rd(`STMR_ADDR_LOW, v);
    chk(v, 8'h05);
    chk({5'h0, amp, oe}, 8'h03);
    chk({4'h0, pout, prd}, 8'h0f);
    wr(`STMR_ADDR_CTRL, 8'h0b);
    repeat (4) @(posedge clk);
    chk({3'h0, amp, oe, prd}, 8'h10);
    stmr_ext_clk_model_i.pulse(3);
    repeat (10) @(posedge clk);
    rd(`STMR_ADDR_LOW, v);
    chk(v, 8'h08);
  endtask : t_ext
  task automatic t_status;
    sel <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`STMR_ADDR_CTRL, v);
    chk(v & 8'h40, 8'h40);
    sel <= 1'b0;
    wr(`STMR_ADDR_CTRL, 8'h40);
    repeat (4) @(posedge clk);
    rd(`STMR_ADDR_CTRL, v);
    chk(v, 8'h00);
  endtask : t_status
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    {rst_b, wr_s, rd_s, sel, match, addr, wdata} = '0;
    mode      = `STMR_CCP_SPECIAL;
    error_cnt = 0;
    n_checks  = 0;
    cyc       = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(`STMR_ADDR_CTRL, v);
    chk(v, `STMR_CTRL_RESET);
    t_prescale();
    t_overflow();
    t_trigger();
    t_buffer();
    t_ext();
    t_status();
    close_out();
  end
endmodule : sixteen_bit_timer_counter_tb
`default_nettype wire
